/* File: ios_pkg.sv */
// constants and carrier types shared by the ethernet io scan engine
package ios_pkg;
  localparam int ENTRIES = 128; // scan table depth
  localparam int IDX_W = 7; // entry index width
  localparam int CLK_PERIOD_NS = 25; // 40 MHz clock period
  localparam int MS_NS = 1000000; // one millisecond in ns
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // clocks per ms
  localparam logic [15:0] MAILBOX_MAX = 16'h0800; // highest mailbox register, 2048
  localparam logic [13:0] REMOTE_MAX = 14'h2000; // highest remote register, 8192
  localparam logic [6:0] CNT_MAX = 7'h78; // largest transfer count, 120
  localparam logic [15:0] BITS_PER_WORD = 16'h0010; // discretes packed per word
  localparam logic [7:0] FC_RD_COIL = 8'h01; // read coils
  localparam logic [7:0] FC_RD_DISC = 8'h02; // read discrete inputs
  localparam logic [7:0] FC_RD_HOLD = 8'h03; // read holding registers
  localparam logic [7:0] FC_RD_INREG = 8'h04; // read input registers
  localparam logic [7:0] FC_WR_COIL = 8'h0F; // write multiple coils
  localparam logic [7:0] FC_WR_HOLD = 8'h10; // write multiple registers
  localparam logic [7:0] FC_RDWR = 8'h17; // combined read/write registers
  // remote register spaces
  typedef enum logic [1:0] {SP_COIL = 2'b00, SP_INPUT = 2'b01, SP_INREG = 2'b10, SP_HOLD = 2'b11} ios_space_t;
  localparam ios_space_t SPACE_DEFAULT = SP_HOLD; // holding registers by default
  // one read or write operation of an entry
  typedef struct packed {
    ios_space_t space; // remote space
    logic [15:0] locStart; // local start register, 1-based, 0 disables
    logic [13:0] remStart; // remote start register, 1-based, 0 disables
    logic [6:0] cnt; // registers or packed words, 0 disables
  } ios_op_t;
  // one scan table entry
  typedef struct packed {
    logic [31:0] ipAddr; // target address
    logic [7:0] unitId; // slave or destination index
    logic [15:0] timeoutMs; // transaction timeout
    logic [15:0] scanMs; // poll interval, 0 means back to back
    ios_op_t rd; // read operation
    ios_op_t wr; // write operation
    logic keepLastValue; // 1 hold data on timeout, 0 clear it
  } ios_entry_t;
  // request handed to the network side
  typedef struct packed {
    logic [IDX_W-1:0] entry; // table index
    logic [31:0] ipAddr; // target address
    logic [7:0] unitId; // unit identifier
    logic [7:0] fc; // function code
    logic [15:0] rdAddr; // zero-based remote read address
    logic [15:0] rdQty; // read quantity
    logic [15:0] wrAddr; // zero-based remote write address
    logic [15:0] wrQty; // write quantity
    logic [15:0] wrLocal; // zero-based local source of write data
  } ios_req_t;
  // engine states
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_WAIT = 2'b10, ST_ZERO = 2'b11} ios_state_t;
endpackage : ios_pkg

/* File: ios_remote_model.sv */
// behavioural remote server that answers scan engine requests
module ios_remote_model
  import ios_pkg::*;
(
  input wire logic clk,
  input wire logic reqValid,
  input wire ios_pkg::ios_req_t req,
  input wire logic silent, // accept but never answer
  output logic reqReady,
  output logic rspWordValid,
  output logic [15:0] rspWord,
  output logic rspDone,
  output logic rspOk
);
  timeunit 1ns;
  timeprecision 100ps;
  ios_req_t r; // request being served
  int n; // words to return
  initial begin
    {reqReady, rspWordValid, rspWord, rspDone, rspOk} = '0;
  end
  // take a request, think two cycles, return one word per cycle then done
  always begin
    @(negedge clk);
    if (reqValid === 1'b1) begin
      reqReady = 1'b1;
      @(posedge clk);
      r = req;
      @(negedge clk);
      reqReady = 1'b0;
      n = (r.fc == FC_RD_COIL || r.fc == FC_RD_DISC) ? (r.rdQty + 15) / 16 : r.rdQty;
      if (r.fc == FC_WR_COIL || r.fc == FC_WR_HOLD) n = 0;
      if (!silent) begin
        repeat (2) @(negedge clk);
        for (int k = 0; k < n; k++) begin
          rspWordValid = 1'b1;
          rspWord = {r.rdAddr[7:0], 8'(k)};
          @(negedge clk);
        end
        rspWordValid = 1'b0;
        rspWord = ~rspWord; // released data does not hold its value
        {rspDone, rspOk} = 2'h3;
        @(negedge clk);
        {rspDone, rspOk} = 2'h0;
      end
    end
  end
endmodule : ios_remote_model

/* File: ios_scan_engine.sv */
// table-driven polling engine that reads and writes remote register blocks
// Overview of operation
// - table of 128 entries with full settings
// - poll remote servers continually without program help
// - unit identifier goes out as slave index
// - abandon transaction when millisecond timeout expires
// - repeat poll each scan interval, zero back-to-back
// - remote space per operation, holding by default
// - local start 1..2048 for mailbox, 0 disables
// - remote start 1..8192, 0 disables entry
// - count 0..120, 0 disables entry
// - count means registers or packed 16-bit words
// - hold setting keeps last read data
// - zero setting clears read destination on timeout
// - read plus write uses function code 23
// - table changes only while offline by image load
// - io module mode limits local start to first 2048 mailbox registers
// - health map, entry 1 msb, written on change
// - skip entries set in enabled disable map
// - same-address entries share one connection serially
module ios_scan_engine
  import ios_pkg::*;
#(
  parameter int MS_CYCLES_P = ios_pkg::MS_CYCLES // clocks per millisecond
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic online, // scanning allowed, table locked
  input wire logic ioMode, // module configured as an io module
  input wire logic disableMapEn, // honour the disable map
  input wire logic [ENTRIES-1:0] disableMap, // entry 1 in msb
  input wire logic loadWe, // image load write strobe
  input wire logic [ios_pkg::IDX_W-1:0] loadIdx, // entry being loaded
  input wire ios_pkg::ios_entry_t loadEntry, // entry contents
  output logic reqValid, // request offered
  input wire logic reqReady, // network side takes the request
  output ios_pkg::ios_req_t req, // request contents
  input wire logic rspWordValid, // one read data word
  input wire logic [15:0] rspWord, // read data
  input wire logic rspDone, // transaction finished
  input wire logic rspOk, // finished without error
  output logic locWe, // local store write
  output logic [15:0] locAddr, // zero-based local register
  output logic [15:0] locData, // local write data
  output logic [ENTRIES-1:0] healthMap, // entry 1 in msb
  output logic healthUpd // health map rewritten this cycle
);
  import ios_pkg::*;

  // operation has any start or count field set
  function automatic logic opPresent(input ios_op_t op);
    opPresent = (op.locStart != '0) || (op.remStart != '0) || (op.cnt != '0);
  endfunction : opPresent

  // operation fully and legally configured
  function automatic logic opValid(input ios_op_t op, input logic isWr, input logic ioM);
    opValid = (op.locStart != '0) && (op.remStart != '0) && (op.cnt != '0)
      && (op.remStart <= REMOTE_MAX) && (op.cnt <= CNT_MAX)
      && (!ioM || (op.locStart <= MAILBOX_MAX))
      && (!isWr || (op.space == SP_COIL) || (op.space == SP_HOLD));
  endfunction : opValid

  // quantity on the wire for a count
  // discrete spaces move packed words, so the wire quantity is in bits
  function automatic logic [15:0] opQty(input ios_op_t op);
    if ((op.space == SP_COIL) || (op.space == SP_INPUT)) begin
      opQty = 16'(op.cnt) * BITS_PER_WORD;
    end else begin
      opQty = 16'(op.cnt);
    end
  endfunction : opQty

  // function code from the operations in use
  function automatic logic [7:0] fcSelect(input logic rdOn, input logic wrOn, input ios_space_t rs,
                                          input ios_space_t ws);
    if (rdOn && wrOn) begin
      fcSelect = FC_RDWR;
    end else if (wrOn) begin
      fcSelect = (ws == SP_COIL) ? FC_WR_COIL : FC_WR_HOLD;
    end else begin
      case (rs)
        SP_COIL: fcSelect = FC_RD_COIL;
        SP_INPUT: fcSelect = FC_RD_DISC;
        SP_INREG: fcSelect = FC_RD_INREG;
        default: fcSelect = FC_RD_HOLD;
      endcase
    end
  endfunction : fcSelect

  ios_entry_t table_r [ENTRIES]; // scan table
  logic [15:0] lastStart_r [ENTRIES]; // ms stamp of each entry's last poll
  logic [ENTRIES-1:0] started_r, started_nxt; // entry polled since reset
  logic [31:0] msCnt_r, msCnt_nxt; // millisecond divider
  logic msTick; // one-cycle ms enable
  logic [15:0] nowMs_r, nowMs_nxt; // free running ms time
  ios_state_t state_r, state_nxt; // engine state
  logic [IDX_W-1:0] ptr_r, ptr_nxt; // entry being served
  ios_entry_t cur_r, cur_nxt; // copy of the active entry
  ios_req_t req_r, req_nxt; // held request
  logic [15:0] tmo_r, tmo_nxt; // ms spent waiting
  logic [6:0] wordCnt_r, wordCnt_nxt; // words written locally
  logic [ENTRIES-1:0] health_r, health_nxt; // entry health
  logic healthUpd_r; // change pulse
  logic locWe_r, locWe_nxt; // local write strobe
  logic [15:0] locAddr_r, locAddr_nxt; // local address
  logic [15:0] locData_r, locData_nxt; // local data
  logic stampEn; // record poll start time
  ios_entry_t ent; // entry under the pointer
  logic rdOn, wrOn, eligible, due; // entry decode
  logic [15:0] elapsed; // ms since last poll
  ios_entry_t tblPeek; // entry at the load index

  assign ent = table_r[ptr_r];
  assign tblPeek = table_r[loadIdx];
  assign rdOn = opPresent(ent.rd);
  assign wrOn = opPresent(ent.wr);
  assign elapsed = nowMs_r - lastStart_r[ptr_r];
  assign due = (ent.scanMs == '0) || !started_r[ptr_r] || (elapsed >= ent.scanMs);
  assign eligible = (rdOn || wrOn) && (!rdOn || opValid(ent.rd, 1'b0, ioMode))
    && (!wrOn || opValid(ent.wr, 1'b1, ioMode)) && !(disableMapEn && disableMap[ENTRIES-1-ptr_r])
    && due;
  assign msTick = (msCnt_r == 32'(MS_CYCLES_P - 1));

  // millisecond time base
  // timers count ticks, so a timeout may end up to one millisecond early
  always_comb begin
    msCnt_nxt = msTick ? '0 : msCnt_r + 32'h0000_0001;
    nowMs_nxt = msTick ? nowMs_r + 16'h0001 : nowMs_r;
  end

  // engine next state: one transaction outstanding at a time, so shared targets run serially
  // one outstanding slot serves every entry, including those that share an address
  always_comb begin
    state_nxt = state_r;
    ptr_nxt = ptr_r;
    cur_nxt = cur_r;
    req_nxt = req_r;
    tmo_nxt = tmo_r;
    wordCnt_nxt = wordCnt_r;
    health_nxt = health_r;
    started_nxt = started_r;
    locWe_nxt = 1'b0;
    locAddr_nxt = locAddr_r;
    locData_nxt = locData_r;
    stampEn = 1'b0;
    reqValid = 1'b0;
    case (state_r)
      ST_IDLE: begin
        // walk the table, one entry per cycle
        if (online && eligible) begin
          cur_nxt = ent;
          req_nxt.entry = ptr_r;
          req_nxt.ipAddr = ent.ipAddr;
          req_nxt.unitId = ent.unitId;
          req_nxt.fc = fcSelect(rdOn, wrOn, ent.rd.space, ent.wr.space);
          req_nxt.rdAddr = rdOn ? 16'(ent.rd.remStart - 14'h0001) : '0;
          req_nxt.rdQty = rdOn ? opQty(ent.rd) : '0;
          req_nxt.wrAddr = wrOn ? 16'(ent.wr.remStart - 14'h0001) : '0;
          req_nxt.wrQty = wrOn ? opQty(ent.wr) : '0;
          req_nxt.wrLocal = wrOn ? ent.wr.locStart - 16'h0001 : '0;
          state_nxt = ST_ISSUE;
        end else begin
          ptr_nxt = ptr_r + 7'h01;
        end
      end
      ST_ISSUE: begin
        // offer the request until taken
        reqValid = 1'b1;
        if (reqReady) begin
          stampEn = 1'b1;
          started_nxt[ptr_r] = 1'b1;
          tmo_nxt = '0;
          wordCnt_nxt = '0;
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // copy returned words to the read destination
        if (rspWordValid && opPresent(cur_r.rd) && (wordCnt_r < cur_r.rd.cnt)) begin
          locWe_nxt = 1'b1;
          locAddr_nxt = cur_r.rd.locStart - 16'h0001 + 16'(wordCnt_r);
          locData_nxt = rspWord;
          wordCnt_nxt = wordCnt_r + 7'h01;
        end
        if (rspDone) begin
          health_nxt[ENTRIES-1-ptr_r] = rspOk;
          ptr_nxt = ptr_r + 7'h01;
          state_nxt = ST_IDLE;
        end else if (msTick) begin
          tmo_nxt = tmo_r + 16'h0001;
          if (tmo_nxt >= cur_r.timeoutMs) begin
            health_nxt[ENTRIES-1-ptr_r] = 1'b0;
            wordCnt_nxt = '0;
            if (opPresent(cur_r.rd) && !cur_r.keepLastValue) begin
              state_nxt = ST_ZERO;
            end else begin
              ptr_nxt = ptr_r + 7'h01;
              state_nxt = ST_IDLE;
            end
          end
        end
      end
      ST_ZERO: begin
        // clear the read destination word by word
        locWe_nxt = 1'b1;
        locAddr_nxt = cur_r.rd.locStart - 16'h0001 + 16'(wordCnt_r);
        locData_nxt = '0;
        wordCnt_nxt = wordCnt_r + 7'h01;
        if (wordCnt_nxt == cur_r.rd.cnt) begin
          ptr_nxt = ptr_r + 7'h01;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // engine registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msCnt_r <= '0;
      nowMs_r <= '0;
      state_r <= ST_IDLE;
      ptr_r <= '0;
      cur_r <= '0;
      req_r <= '0;
      tmo_r <= '0;
      wordCnt_r <= '0;
      health_r <= '0;
      healthUpd_r <= 1'b0;
      started_r <= '0;
      locWe_r <= 1'b0;
      locAddr_r <= '0;
      locData_r <= '0;
    end else begin
      msCnt_r <= msCnt_nxt;
      nowMs_r <= nowMs_nxt;
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      cur_r <= cur_nxt;
      req_r <= req_nxt;
      tmo_r <= tmo_nxt;
      wordCnt_r <= wordCnt_nxt;
      health_r <= health_nxt;
      healthUpd_r <= (health_nxt != health_r);
      started_r <= started_nxt;
      locWe_r <= locWe_nxt;
      locAddr_r <= locAddr_nxt;
      locData_r <= locData_nxt;
    end
  end

  // table load and poll time stamps, memories without reset
  // loads are refused while online, so a scan never reads a half-written entry
  always_ff @(posedge clk) begin
    if (loadWe && !online) begin
      table_r[loadIdx] <= loadEntry;
    end
    if (stampEn) begin
      lastStart_r[ptr_r] <= nowMs_r;
    end
  end

  assign req = req_r;
  assign locWe = locWe_r;
  assign locAddr = locAddr_r;
  assign locData = locData_r;
  assign healthMap = health_r;
  assign healthUpd = healthUpd_r;

  // engine checks, masked while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  table_lock_a: assert property (online && loadWe |=> table_r[$past(loadIdx)] == $past(tblPeek))
    else $error("table changed while online");
  unit_id_a: assert property (reqValid |-> req.unitId == cur_r.unitId && req.entry == ptr_r)
    else $error("request unit id wrong");
  rdwr_code_a: assert property (reqValid && opPresent(cur_r.rd) && opPresent(cur_r.wr) |-> req.fc == FC_RDWR)
    else $error("combined request not code 23");
  disable_skip_a: assert property (reqValid && disableMapEn |-> !disableMap[ENTRIES-1-ptr_r])
    else $error("disabled entry polled");
  packed_qty_a: assert property (reqValid && cur_r.rd.space == SP_COIL && opPresent(cur_r.rd)
    |-> req.rdQty == 16'(cur_r.rd.cnt) * BITS_PER_WORD)
    else $error("discrete quantity wrong");
  health_change_a: assert property (healthUpd |-> healthMap != $past(healthMap))
    else $error("health update without change");
  zero_fill_a: assert property (state_r == ST_ZERO |=> locWe && locData == '0 && !cur_r.keepLastValue)
    else $error("timeout clear wrong");
  timeout_end_a: assert property (state_r == ST_WAIT && msTick && !rspDone && tmo_r + 16'h0001 >= cur_r.timeoutMs
    |=> state_r != ST_WAIT)
    else $error("timeout not honoured");
  scan_gap_a: assert property (reqValid && reqReady && started_r[ptr_r] && cur_r.scanMs != '0
    |-> nowMs_r - lastStart_r[ptr_r] >= cur_r.scanMs)
    else $error("poll before scan interval");
  single_txn_a: assert property ($rose(reqValid) |-> $past(state_r) == ST_IDLE ##1 !reqValid || state_r == ST_ISSUE)
    else $error("overlapping transaction");
  wait_quiet_a: assert property (state_r == ST_WAIT |-> !reqValid)
    else $error("request during open transaction");
  dest_range_a: assert property (locWe |-> locAddr - (cur_r.rd.locStart - 16'h0001) < 16'(cur_r.rd.cnt))
    else $error("local write outside read destination");
endmodule : ios_scan_engine

/* File: tb_ios_scan_engine.sv */
// self-checking bench for the scan engine against a remote server model
module tb_ios_scan_engine import ios_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    ios_space_t rs; logic [6:0] rc; ios_space_t ws; logic [6:0] wc; logic ioMd; logic [7:0] fc; logic [15:0] q;
  } ios_case_t; // one function code case
  logic clk, sys_rst, online, ioMode, disableMapEn, loadWe, reqValid, reqReady, silent;
  logic rspWordValid, rspDone, rspOk, locWe, healthUpd;
  logic [ENTRIES-1:0] disableMap, healthMap;
  logic [IDX_W-1:0] loadIdx;
  logic [15:0] rspWord, locAddr, locData;
  ios_entry_t loadEntry;
  ios_req_t req;
  int miscompares, check_count, cyc, updCount;
  logic [31:0] wrQ[$]; // local writes, address and data
  int accQ[$]; // cycles of request acceptance
  ios_scan_engine #(.MS_CYCLES_P(10)) u_ios_scan_engine (.clk(clk), .sys_rst(sys_rst), .online(online),
    .ioMode(ioMode), .disableMapEn(disableMapEn), .disableMap(disableMap), .loadWe(loadWe), .loadIdx(loadIdx),
    .loadEntry(loadEntry), .reqValid(reqValid), .reqReady(reqReady), .req(req), .rspWordValid(rspWordValid),
    .rspWord(rspWord), .rspDone(rspDone), .rspOk(rspOk), .locWe(locWe), .locAddr(locAddr), .locData(locData),
    .healthMap(healthMap), .healthUpd(healthUpd));
  ios_remote_model u_ios_remote_model (.clk(clk), .reqValid(reqValid), .req(req), .silent(silent),
    .reqReady(reqReady), .rspWordValid(rspWordValid), .rspWord(rspWord), .rspDone(rspDone), .rspOk(rspOk));
  always #12.5 clk = ~clk;
  // record local writes, health pulses and accepted requests
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (locWe === 1'b1) wrQ.push_back({locAddr, locData});
    if (healthUpd === 1'b1) updCount++;
    if (reqValid === 1'b1 && reqReady === 1'b1) accQ.push_back(cyc);
  end
  task automatic chk(string what, logic [127:0] seen, logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // read-only entry, 20 ms timeout, back-to-back polling
  function automatic ios_entry_t rdEnt(ios_space_t s, logic [15:0] l, logic [13:0] m, logic [6:0] c);
    rdEnt = '{32'h0A000005, 8'h2C, 16'h0014, 16'h0000, '{s, l, m, c}, '0, 1'b0};
  endfunction : rdEnt
  task automatic load(int idx, ios_entry_t e);
    @(negedge clk);
    {loadWe, loadIdx, loadEntry} = {1'b1, idx[IDX_W-1:0], e};
    @(negedge clk);
    loadWe = 1'b0;
  endtask : load
  // reset, load entry 0 offline, then go online
  task automatic restart(ios_entry_t e);
    @(negedge clk);
    {online, sys_rst} = 2'b01;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    load(0, e);
    wrQ.delete();
    accQ.delete();
    updCount = 0;
    online = 1'b1;
  endtask : restart
  task automatic wait_req(output ios_req_t r, input int lim);
    int i;
    for (i = 0; i < lim && !(reqValid === 1'b1 && reqReady === 1'b1); i++) @(posedge clk);
    r = req;
    @(posedge clk);
    if (i == lim) begin
      chk("request", 1'b0, 1'b1);
      print_verdict();
    end
  endtask : wait_req
  task automatic no_req(int lim);
    logic seen;
    seen = 1'b0;
    repeat (lim) begin
      @(posedge clk);
      if (reqValid !== 1'b0) seen = 1'b1;
    end
    chk("idle", seen, 1'b0);
  endtask : no_req
  task automatic wait_health(logic v);
    int i;
    for (i = 0; i < 400 && healthMap[127] !== v; i++) @(posedge clk);
    chk("health", healthMap[127], v);
    if (i == 400) print_verdict();
  endtask : wait_health
  task automatic t_read();
    ios_req_t r;
    restart(rdEnt(SPACE_DEFAULT, 16'h0005, 14'h0064, 7'h03));
    wait_req(r, 300);
    chk("fc", r.fc, FC_RD_HOLD);
    chk("unit", r.unitId, 8'h2C);
    chk("ip", r.ipAddr, 32'h0A000005);
    chk("rdAddr", r.rdAddr, 16'h0063);
    chk("rdQty", r.rdQty, 16'h0003);
    wait_req(r, 300);
    chk("spacing", accQ[1] - accQ[0] < 150, 1'b1);
    chk("writes", wrQ.size(), 3);
    for (int k = 0; k < 3; k++) chk("wr", wrQ[k], {16'h0004 + k[15:0], 16'h6300 + k[15:0]});
    chk("healthy", healthMap, 128'h1 << 127);
    chk("updates", updCount, 1);
  endtask : t_read
  task automatic t_codes();
    ios_case_t cs[7] = '{'{SP_COIL, 7'h02, SP_HOLD, 7'h00, 1'b0, FC_RD_COIL, 16'h0020},
      '{SP_INPUT, 7'h02, SP_HOLD, 7'h00, 1'b0, FC_RD_DISC, 16'h0020},
      '{SP_INREG, 7'h02, SP_HOLD, 7'h00, 1'b0, FC_RD_INREG, 16'h0002},
      '{SP_HOLD, 7'h78, SP_HOLD, 7'h00, 1'b1, FC_RD_HOLD, 16'h0078},
      '{SP_HOLD, 7'h00, SP_HOLD, 7'h02, 1'b0, FC_WR_HOLD, 16'h0002},
      '{SP_HOLD, 7'h00, SP_COIL, 7'h02, 1'b0, FC_WR_COIL, 16'h0020},
      '{SP_HOLD, 7'h02, SP_HOLD, 7'h02, 1'b0, FC_RDWR, 16'h0002}};
    ios_entry_t e;
    ios_req_t r;
    foreach (cs[i]) begin
      e = rdEnt(cs[i].rs, cs[i].ioMd ? 16'h0800 : {15'h0000, cs[i].rc != 0},
        cs[i].ioMd ? 14'h2000 : {13'h0000, cs[i].rc != 0}, cs[i].rc);
      e.wr = (cs[i].wc != 0) ? ios_op_t'{cs[i].ws, 16'h0100, 14'h0200, cs[i].wc} : '0;
      @(negedge clk);
      ioMode = cs[i].ioMd;
      restart(e);
      wait_req(r, 300);
      chk("fc", r.fc, cs[i].fc);
      chk("qty", cs[i].rc != 0 ? r.rdQty : r.wrQty, cs[i].q);
      if (cs[i].wc != 0) begin
        chk("wrAddr", r.wrAddr, 16'h01FF);
        chk("wrLocal", r.wrLocal, 16'h00FF);
      end
    end
  endtask : t_codes
  task automatic t_disabled();
    ios_entry_t bad[6] = '{rdEnt(SP_HOLD, 16'h0000, 14'h0001, 7'h02), rdEnt(SP_HOLD, 16'h0001, 14'h0000, 7'h02),
      rdEnt(SP_HOLD, 16'h0001, 14'h0001, 7'h00), rdEnt(SP_HOLD, 16'h0001, 14'h2001, 7'h02),
      rdEnt(SP_HOLD, 16'h0001, 14'h0001, 7'h79), rdEnt(SP_HOLD, 16'h0801, 14'h0001, 7'h02)};
    ios_entry_t e;
    ios_req_t r;
    foreach (bad[i]) begin
      @(negedge clk);
      ioMode = (i == 5);
      restart(bad[i]);
      no_req(200);
    end
    e = rdEnt(SP_HOLD, 16'h0000, 14'h0000, 7'h00);
    e.wr = '{SP_INREG, 16'h0001, 14'h0001, 7'h02};
    restart(e);
    no_req(200);
    @(negedge clk);
    {ioMode, disableMapEn, disableMap} = {2'b01, 128'h1 << 127};
    restart(rdEnt(SP_HOLD, 16'h0001, 14'h0001, 7'h02));
    no_req(200);
    @(negedge clk);
    disableMap = 128'h1 << 126;
    wait_req(r, 300);
    chk("entry", r.entry, 7'h00);
    @(negedge clk);
    disableMapEn = 1'b0;
  endtask : t_disabled
  task automatic t_timeout(logic keep);
    ios_entry_t e;
    ios_req_t r;
    e = rdEnt(SP_HOLD, 16'h000A, 14'h0031, 7'h02);
    {e.timeoutMs, e.scanMs, e.keepLastValue} = {16'h0002, 16'h0005, keep};
    restart(e);
    wait_req(r, 300);
    wait_health(1'b1);
    @(negedge clk);
    silent = 1'b1;
    wait_req(r, 300);
    chk("interval", accQ[1] - accQ[0] >= 40 && accQ[1] - accQ[0] <= 190, 1'b1);
    wait_health(1'b0);
    chk("abandon", cyc - accQ[1] >= 9 && cyc - accQ[1] <= 32, 1'b1);
    repeat (8) @(posedge clk);
    chk("nwr", wrQ.size(), keep ? 2 : 4);
    for (int i = 0; i < wrQ.size(); i++) begin
      chk("wr", wrQ[i], {16'h0009 + 16'(i % 2), i < 2 ? 16'h3000 + i[15:0] : 16'h0000});
    end
    @(negedge clk);
    silent = 1'b0;
  endtask : t_timeout
  task automatic t_lock();
    ios_req_t r;
    restart(rdEnt(SP_HOLD, 16'h0001, 14'h0001, 7'h04));
    load(0, '0);
    wait_req(r, 300);
    wait_req(r, 300);
    chk("locked", r.rdQty, 16'h0004);
  endtask : t_lock
  initial begin
    {clk, sys_rst, online, ioMode, disableMapEn, loadWe, silent} = 7'h20;
    {disableMap, loadIdx, loadEntry} = '0;
    {miscompares, check_count, cyc, updCount} = '0;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    chk("reset", {reqValid, locWe, healthUpd, locAddr, locData}, 35'h0);
    chk("reset map", healthMap, '0);
    for (int i = 0; i < ENTRIES; i++) load(i, '0);
    t_read();
    t_codes();
    t_disabled();
    t_timeout(1'b0);
    t_timeout(1'b1);
    t_lock();
    print_verdict();
  end
endmodule : tb_ios_scan_engine
